// ==== cpu_model.sv ====
`timescale 1ns/1ps
module cpu_model #(
  parameter logic [15:0] START = 16'h0100
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [1:0] lat,
  input  wire logic       vec_rd_req,
  input  wire logic       irq_req,
  output logic            vec_rd_valid,
  output logic [15:0]     vec_rd_data,
  output logic            insn_done,
  output logic            irq_ack
);
  logic [1:0] cnt_reg;
  wire        tick = cnt_reg == lat;
  // A released bus shows the inverse word, so stale data never matches.
  assign vec_rd_data = vec_rd_valid ? START : ~START;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 2'h0;
      vec_rd_valid <= 1'b0;
      insn_done <= 1'b0;
      irq_ack <= 1'b0;
    end else begin
      cnt_reg <= tick ? 2'h0 : cnt_reg + 2'h1;
      vec_rd_valid <= vec_rd_req && tick && !vec_rd_valid;
      insn_done <= tick && !vec_rd_req && !vec_rd_valid;
      irq_ack <= irq_req && tick && !irq_ack;
    end
  end
endmodule

// ==== reset_and_interrupt_control.sv ====
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module reset_and_interrupt_control
  import ric_pkg::*;
#(
  parameter int AXI_ADDR_W = REG_ADDR_W
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  external_init_pin,
  input  wire ext_pins_s             pins,
  input  wire logic [12:0]           pin_int_func,
  input  wire logic [1:0]            aec_edge_mode,
  input  wire periph_evt_s           periph_evt,
  input  wire logic                  insn_done,
  input  wire logic                  irq_ack,
  input  wire logic                  cond_code_reg_i_wr,
  input  wire logic                  cond_code_reg_i_val,
  input  wire logic                  vec_rd_valid,
  input  wire logic [15:0]           vec_rd_data,
  output logic                       cpu_halt,
  output logic                       vec_rd_req,
  output logic [15:0]                vec_rd_addr,
  output logic                       pc_load,
  output logic [15:0]                pc_value,
  output logic                       mask_flag,
  output logic                       irq_req,
  output logic [4:0]                 irq_vector,
  output logic                       converter_trig_evt,
  output logic                       timer_f_evt,
  output logic                       timer_c_evt,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready
);

  // ----------------------------------------------------------------
  // Elaboration check.
  // ----------------------------------------------------------------
  if (AXI_ADDR_W < REG_ADDR_W) begin : g_addr_chk
    $error("Address width too small for the register indices.");
  end

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  ctl_state_e  state_reg;
  ctl_state_e  state_next;
  logic [15:0] pin_prev_reg;
  logic [7:0]  wake_edge_reg;
  logic [7:0]  pin_edge_reg;
  logic [7:0]  en_one_reg;
  logic [7:0]  en_two_reg;
  logic [7:0]  pend_one_reg;
  logic [7:0]  pend_two_reg;
  logic [7:0]  wake_pend_reg;
  logic [7:0]  pend_one_next;
  logic [7:0]  pend_two_next;
  logic [7:0]  wake_pend_next;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [15:0] aw_idx_reg;
  logic        aw_bad_reg;
  logic [7:0]  wbyte_reg;
  logic        wlane_reg;
  logic [4:0]  best_vec;

  wire         in_reset  = ~external_init_pin;
  wire  [15:0] pin_now   = pins;
  wire  [15:0] rise_v    = pin_now & ~pin_prev_reg;
  wire  [15:0] fall_v    = ~pin_now & pin_prev_reg;
  wire         e4        = pin_edge_reg[EDGE_B4];
  wire         e3        = pin_edge_reg[EDGE_B3];
  wire         e1        = pin_edge_reg[EDGE_B1];
  wire         e0        = pin_edge_reg[EDGE_B0];
  wire         aec_rise  = aec_edge_mode == AEC_RISE;
  wire         aec_both  = aec_edge_mode == AEC_BOTH;

  // ----------------------------------------------------------------
  // Edge detection.
  // ----------------------------------------------------------------
  // Order: wake 7..0, pin 4, pin 3, event pin, pin 1, pin 0,
  // converter trigger, timer F, timer C.
  wire  [15:0] rise_sel  = {wake_edge_reg, e4, e3, aec_rise,
                            e1, e0, e4, e3, e1};
  wire  [15:0] edge_hit  = (rise_sel & rise_v) | (~rise_sel & fall_v);
  wire         aec_hit   = aec_both ? (rise_v[5] | fall_v[5])
                                    : edge_hit[5];
  wire  [12:0] raw_hit   = {edge_hit[15:6], aec_hit, edge_hit[4:3]};
  wire  [12:0] pin_hit   = raw_hit & pin_int_func;

  // ----------------------------------------------------------------
  // Flag set sources; sets never depend on the mask flag.
  // ----------------------------------------------------------------
  wire  [7:0]  set_one   = {periph_evt.timer_a, 2'b00, pin_hit[4:0]};
  wire  [7:0]  set_two   = {periph_evt.direct_xfer, periph_evt.adc_end,
                            1'b0, periph_evt.timer_g,
                            periph_evt.timer_fh, periph_evt.timer_fl,
                            periph_evt.timer_c, periph_evt.event_ctr};
  wire  [7:0]  set_wake  = pin_hit[12:5];

  // ----------------------------------------------------------------
  // Register write decode.
  // ----------------------------------------------------------------
  wire         wr_fire   = aw_full_reg & w_full_reg & ~bvalid;
  wire         wr_do     = wr_fire & wlane_reg & ~aw_bad_reg & ~in_reset;
  wire         wr_wedge  = wr_do & (aw_idx_reg == IDX_WAKE_EDGE);
  wire         wr_pedge  = wr_do & (aw_idx_reg == IDX_PIN_EDGE);
  wire         wr_en1    = wr_do & (aw_idx_reg == IDX_EN_ONE);
  wire         wr_en2    = wr_do & (aw_idx_reg == IDX_EN_TWO);
  wire         wr_p1     = wr_do & (aw_idx_reg == IDX_PEND_ONE);
  wire         wr_p2     = wr_do & (aw_idx_reg == IDX_PEND_TWO);
  wire         wr_wp     = wr_do & (aw_idx_reg == IDX_WAKE_PEND);
  wire  [7:0]  clr_byte  = ~wbyte_reg;
  wire  [7:0]  clr_one   = wr_p1 ? clr_byte : 8'h00;
  wire  [7:0]  clr_two   = wr_p2 ? clr_byte : 8'h00;
  wire  [7:0]  clr_wake  = wr_wp ? clr_byte : 8'h00;
  wire  [15:0] aw_idx_in = awaddr[17:2];
  wire         aw_bad_in = awaddr[1:0] != 2'b00;

  // Set wins over a clear in the same cycle; acceptance clears nothing.
  assign pend_one_next  = ((pend_one_reg & ~clr_one) | set_one)
                          & PEND_ONE_MASK;
  assign pend_two_next  = ((pend_two_reg & ~clr_two) | set_two)
                          & PEND_TWO_MASK;
  assign wake_pend_next = ((wake_pend_reg & ~clr_wake) | set_wake)
                          & WAKE_MASK;

  // ----------------------------------------------------------------
  // Request gating and priority.
  // ----------------------------------------------------------------
  wire  [NUM_SRC-1:0] req = {
    pend_two_reg[B2_DT]  & en_two_reg[B2_DT],
    pend_two_reg[B2_AD]  & en_two_reg[B2_AD],
    |periph_evt.serial_cond,
    pend_two_reg[B2_TG]  & en_two_reg[B2_TG],
    pend_two_reg[B2_TFH] & en_two_reg[B2_TFH],
    pend_two_reg[B2_TFL] & en_two_reg[B2_TFL],
    pend_two_reg[B2_TC]  & en_two_reg[B2_TC],
    pend_two_reg[B2_EC]  & en_two_reg[B2_EC],
    pend_one_reg[B1_TA]  & en_one_reg[B1_TA],
    (|wake_pend_reg)     & en_one_reg[B1_WAKE],
    pend_one_reg[B1_EXT_INT_PIN_4] & en_one_reg[B1_EXT_INT_PIN_4],
    pend_one_reg[B1_EXT_INT_PIN_3] & en_one_reg[B1_EXT_INT_PIN_3],
    pend_one_reg[B1_AEC]  & en_one_reg[B1_AEC],
    pend_one_reg[B1_EXT_INT_PIN_1] & en_one_reg[B1_EXT_INT_PIN_1],
    pend_one_reg[B1_EXT_INT_PIN_0] & en_one_reg[B1_EXT_INT_PIN_0]};
  wire         any_req   = |req;
  wire         accept_ok = any_req & ~mask_flag;

  // Scanning from lowest to highest lets the highest overwrite.
  always_comb begin
    best_vec = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        best_vec = SRC_VEC[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencing of reset and exceptions.
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: begin
        if (!in_reset) begin
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (vec_rd_valid) begin
          state_next = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (insn_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (insn_done && accept_ok) begin
          state_next = ST_OFFER;
        end
      end
      ST_OFFER: begin
        if (irq_ack) begin
          state_next = ST_EXC;
        end
      end
      ST_EXC: begin
        if (insn_done) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
    if (in_reset) begin
      state_next = ST_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= ST_RESET;
      pin_prev_reg <= 16'hFFFF;
    end else begin
      state_reg    <= state_next;
      pin_prev_reg <= pin_now;
    end
  end

  // ----------------------------------------------------------------
  // CPU-facing outputs.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_halt    <= 1'b1;
      vec_rd_req  <= 1'b0;
      vec_rd_addr <= RESET_VEC_ADDR;
      pc_load     <= 1'b0;
      pc_value    <= 16'h0000;
      irq_req     <= 1'b0;
      irq_vector  <= 5'h00;
    end else begin
      cpu_halt    <= state_next == ST_RESET;
      vec_rd_req  <= state_next == ST_FETCH;
      vec_rd_addr <= RESET_VEC_ADDR;
      pc_load     <= (state_reg == ST_FETCH) && vec_rd_valid && !in_reset;
      if (state_reg == ST_FETCH && vec_rd_valid) begin
        pc_value  <= vec_rd_data;
      end
      irq_req     <= state_next == ST_OFFER;
      if (state_reg == ST_RUN && state_next == ST_OFFER) begin
        irq_vector <= best_vec;
      end
    end
  end

  // The mask flag mirrors the CPU's own bit so that acceptance and
  // software updates of that bit cannot race each other here.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_flag <= 1'b1;
    end else if (in_reset || (state_reg == ST_OFFER && irq_ack)) begin
      mask_flag <= 1'b1;
    end else if (cond_code_reg_i_wr) begin
      mask_flag <= cond_code_reg_i_val;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      converter_trig_evt <= 1'b0;
      timer_f_evt        <= 1'b0;
      timer_c_evt        <= 1'b0;
    end else begin
      converter_trig_evt <= edge_hit[2] & ~in_reset;
      timer_f_evt        <= edge_hit[1] & ~in_reset;
      timer_c_evt        <= edge_hit[0] & ~in_reset;
    end
  end

  // ----------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_edge_reg <= REG_RESET;
      pin_edge_reg  <= REG_RESET;
      en_one_reg    <= REG_RESET;
      en_two_reg    <= REG_RESET;
      pend_one_reg  <= REG_RESET;
      pend_two_reg  <= REG_RESET;
      wake_pend_reg <= REG_RESET;
    end else if (in_reset) begin
      wake_edge_reg <= REG_RESET;
      pin_edge_reg  <= REG_RESET;
      en_one_reg    <= REG_RESET;
      en_two_reg    <= REG_RESET;
      pend_one_reg  <= REG_RESET;
      pend_two_reg  <= REG_RESET;
      wake_pend_reg <= REG_RESET;
    end else begin
      if (wr_wedge) begin
        wake_edge_reg <= wbyte_reg;
      end
      if (wr_pedge) begin
        pin_edge_reg <= wbyte_reg & PIN_EDGE_WMASK;
      end
      if (wr_en1) begin
        en_one_reg <= wbyte_reg & EN_ONE_WMASK;
      end
      if (wr_en2) begin
        en_two_reg <= wbyte_reg & EN_TWO_WMASK;
      end
      pend_one_reg  <= pend_one_next;
      pend_two_reg  <= pend_two_next;
      wake_pend_reg <= wake_pend_next;
    end
  end

  // ----------------------------------------------------------------
  // Register read decode.
  // ----------------------------------------------------------------
  wire  [15:0] ar_idx   = araddr[17:2];
  wire         ar_align = araddr[1:0] == 2'b00;
  wire  [7:0]  status_b = {mask_flag, irq_req, any_req, best_vec};
  wire         ar_hit   = ar_align &&
                          (ar_idx == IDX_WAKE_EDGE || ar_idx == IDX_PIN_EDGE
                          || ar_idx == IDX_EN_ONE  || ar_idx == IDX_EN_TWO
                          || ar_idx == IDX_PEND_ONE || ar_idx == IDX_PEND_TWO
                          || ar_idx == IDX_WAKE_PEND || ar_idx == IDX_STATUS);
  wire  [7:0]  rd_byte  =
    (ar_idx == IDX_WAKE_EDGE) ? wake_edge_reg :
    (ar_idx == IDX_PIN_EDGE)  ? (pin_edge_reg | PIN_EDGE_FIXED) :
    (ar_idx == IDX_EN_ONE)    ? en_one_reg :
    (ar_idx == IDX_EN_TWO)    ? en_two_reg :
    (ar_idx == IDX_PEND_ONE)  ? (pend_one_reg | PEND_ONE_FIXED) :
    (ar_idx == IDX_PEND_TWO)  ? pend_two_reg :
    (ar_idx == IDX_WAKE_PEND) ? wake_pend_reg :
    (ar_idx == IDX_STATUS)    ? status_b : 8'h00;

  // ----------------------------------------------------------------
  // Bus slave: one write and one read at a time.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_idx_reg  <= 16'h0000;
      aw_bad_reg  <= 1'b0;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready     <= 1'b0;
        aw_full_reg <= 1'b1;
        aw_idx_reg  <= aw_idx_in;
        aw_bad_reg  <= aw_bad_in || !(aw_idx_in == IDX_WAKE_EDGE
          || aw_idx_in == IDX_PIN_EDGE || aw_idx_in == IDX_EN_ONE
          || aw_idx_in == IDX_EN_TWO || aw_idx_in == IDX_PEND_ONE
          || aw_idx_in == IDX_PEND_TWO || aw_idx_in == IDX_WAKE_PEND
          || aw_idx_in == IDX_STATUS);
      end
      if (wvalid && wready) begin
        wready     <= 1'b0;
        w_full_reg <= 1'b1;
        wbyte_reg  <= wdata[7:0];
        wlane_reg  <= wstrb[0];
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= aw_bad_reg ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid      <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        awready     <= 1'b1;
        wready      <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, ar_hit ? rd_byte : 8'h00};
      rresp   <= ar_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule

// ==== ric_checker.sv ====
`timescale 1ns/1ps
module ric_checker (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        external_init_pin,
  input wire logic        insn_done,
  input wire logic        irq_ack,
  input wire logic        vec_rd_valid,
  input wire logic [15:0] vec_rd_data,
  input wire logic        cpu_halt,
  input wire logic        vec_rd_req,
  input wire logic        pc_load,
  input wire logic [15:0] pc_value,
  input wire logic        mask_flag,
  input wire logic        irq_req,
  input wire logic [4:0]  irq_vector
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_fetch; vec_rd_req && vec_rd_valid; endsequence
  sequence s_take; irq_req && irq_ack; endsequence
  a_halt_init: assert property (
    !external_init_pin |=> cpu_halt && mask_flag && !irq_req)
    else $error("no halt");
  a_pc_word: assert property (
    s_fetch |=> pc_load && pc_value == $past(vec_rd_data)) else $error("pc");
  a_boot_mask: assert property (
    $rose(pc_load) |-> mask_flag) else $error("boot unmasked");
  a_first_insn: assert property (
    pc_load |=> !irq_req [*2]) else $error("early irq");
  a_irq_cause: assert property (
    $rose(irq_req) |-> $past(insn_done) && !$past(mask_flag))
    else $error("irq out of turn");
  a_take_mask: assert property (
    s_take |=> mask_flag && !irq_req) else $error("ack ignored");
  a_irq_hold: assert property (
    irq_req && !irq_ack && external_init_pin |=> irq_req &&
    $stable(irq_vector)) else $error("offer dropped");
  a_vec_legal: assert property (
    irq_req |-> irq_vector inside {[5'h04:5'h09], [5'h0B:5'h10],
    [5'h12:5'h14]}) else $error("reserved vector");
endmodule
bind reset_and_interrupt_control ric_checker u_chk (.*);

// ==== ric_pkg.sv ====
// Notes on behaviour
// - Reset outranks interrupts; starts right after release.
// - Interrupt waits for current instruction or exception.
// - Init pin low halts everything immediately.
// - Reset initialises registers and sets mask flag.
// - Program counter loads from reset vector word.
// - First instruction always runs before any interrupt.
// - Thirteen external, nine internal sources, fixed priority.
// - Mask flag blocks acceptance, flags still set.
// - Pins sense either edge; event pin both.
// - Vectors four to nine, then internal sources.
// - All serial port conditions share vector eighteen.
// - Direct transfer uses vector twenty, lowest priority.
// - Reserved vector slots never assigned.
// - Request flags clear only by writing zero or by reset.
// - Edge select bits seven to five read one.
// - Edge bit four: pin four and converter trigger.
// - Edge bit three: pin three and timer F.
// - Edge bit one: pin one and timer C.
// - Edge bit zero: pin zero, falling default.
// - Pin flag sets on selected edge when enabled.
// - Flags never clear on interrupt acceptance.
package ric_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // ----------------------------------------------------------------
  localparam int          REG_ADDR_W     = 18;
  localparam logic [15:0] IDX_WAKE_EDGE  = 16'hFF90;
  localparam logic [15:0] IDX_PIN_EDGE   = 16'hFFF2;
  localparam logic [15:0] IDX_EN_ONE     = 16'hFFF3;
  localparam logic [15:0] IDX_EN_TWO     = 16'hFFF4;
  localparam logic [15:0] IDX_PEND_ONE   = 16'hFFF6;
  localparam logic [15:0] IDX_PEND_TWO   = 16'hFFF7;
  localparam logic [15:0] IDX_WAKE_PEND  = 16'hFFF9;
  localparam logic [15:0] IDX_STATUS     = 16'hFFFA;

  // ----------------------------------------------------------------
  // Reset values, fixed bits and writable masks.
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  PIN_EDGE_FIXED = 8'hE0;
  localparam logic [7:0]  PIN_EDGE_WMASK = 8'h1B;
  localparam logic [7:0]  EN_ONE_WMASK   = 8'hBF;
  localparam logic [7:0]  EN_TWO_WMASK   = 8'hDF;
  localparam logic [7:0]  PEND_ONE_FIXED = 8'h20;
  localparam logic [7:0]  PEND_ONE_MASK  = 8'h9F;
  localparam logic [7:0]  PEND_TWO_MASK  = 8'hDF;
  localparam logic [7:0]  WAKE_MASK      = 8'hFF;

  // ----------------------------------------------------------------
  // Bit positions in enable, pending and edge select registers.
  // ----------------------------------------------------------------
  localparam int B1_EXT_INT_PIN_0 = 0;
  localparam int B1_EXT_INT_PIN_1 = 1;
  localparam int B1_AEC  = 2;
  localparam int B1_EXT_INT_PIN_3 = 3;
  localparam int B1_EXT_INT_PIN_4 = 4;
  localparam int B1_WAKE = 5;
  localparam int B1_TA   = 7;
  localparam int B2_EC   = 0;
  localparam int B2_TC   = 1;
  localparam int B2_TFL  = 2;
  localparam int B2_TFH  = 3;
  localparam int B2_TG   = 4;
  localparam int B2_AD   = 6;
  localparam int B2_DT   = 7;
  localparam int EDGE_B0 = 0;
  localparam int EDGE_B1 = 1;
  localparam int EDGE_B3 = 3;
  localparam int EDGE_B4 = 4;

  // ----------------------------------------------------------------
  // Vectors, indexed by source from highest priority (0) down.
  // ----------------------------------------------------------------
  localparam int          NUM_SRC        = 15;
  localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
  localparam logic [NUM_SRC-1:0][4:0] SRC_VEC = {
    5'h14, 5'h13, 5'h12, 5'h10, 5'h0F, 5'h0E, 5'h0D, 5'h0C,
    5'h0B, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04};

  localparam logic [1:0] AEC_FALL = 2'h0;
  localparam logic [1:0] AEC_RISE = 2'h1;
  localparam logic [1:0] AEC_BOTH = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carriers and states.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] wake_pins;
    logic       ext_int_pin_4;
    logic       ext_int_pin_3;
    logic       event_counter_int_pin;
    logic       ext_int_pin_1;
    logic       ext_int_pin_0;
    logic       converter_trigger_pin;
    logic       timer_f_event_pin;
    logic       timer_c_event_pin;
  } ext_pins_s;

  typedef struct packed {
    logic       timer_a;
    logic       event_ctr;
    logic       timer_c;
    logic       timer_fl;
    logic       timer_fh;
    logic       timer_g;
    logic       adc_end;
    logic       direct_xfer;
    logic [5:0] serial_cond;
  } periph_evt_s;

  typedef enum logic [2:0] {
    ST_RESET, ST_FETCH, ST_FIRST, ST_RUN, ST_OFFER, ST_EXC
  } ctl_state_e;

endpackage

// ==== tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
  $display("FAIL %s exp %0h got %0h", n, e, s); end end
module tb
  import ric_pkg::*;
;
  logic core_clk, nrst, external_init_pin, insn_done, irq_ack, cpu_halt;
  logic cond_code_reg_i_wr, cond_code_reg_i_val, vec_rd_valid, vec_rd_req;
  logic pc_load, mask_flag, irq_req, converter_trig_evt, timer_f_evt;
  logic timer_c_evt, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] aec_edge_mode, bresp, rresp, lat, rd_r;
  logic [3:0] wstrb;
  logic [4:0] irq_vector;
  logic [7:0] rd_v, es, ws, w, b;
  logic [12:0] pin_int_func;
  logic [15:0] vec_rd_data, vec_rd_addr, pc_value;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  ext_pins_s pins;
  periph_evt_s periph_evt;
  wire [2:0] evt = {converter_trig_evt, timer_f_evt, timer_c_evt};
  int fails, tests_run, p1, p2, wk, v;
  logic [15:0] ri[7] = '{IDX_WAKE_EDGE, IDX_PIN_EDGE, IDX_EN_ONE,
    IDX_EN_TWO, IDX_PEND_ONE, IDX_PEND_TWO, IDX_WAKE_PEND};
  logic [7:0] rv[7] = '{8'h00, 8'hE0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
  reset_and_interrupt_control u_dut (.*);
  cpu_model u_cpu (.*);
  always #50 core_clk = ~core_clk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    `CHK("bresp", 2'h0, bresp)
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] e);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_v = rdata[7:0];
    rd_r = rresp;
    `CHK($sformatf("reg %h", i), e, rd_v)
  endtask
  task automatic put_pins(input logic [15:0] nv);
    logic [15:0] s, h, r, f;
    logic [1:0] m;
    m = 2'($urandom);
    s = {ws, es[4:3], 1'b0, es[1:0], es[4:3], es[1]};
    r = nv & ~pins;
    f = ~nv & pins;
    h = (r & s) | (f & ~s);
    if (m == 2'h1) h[5] = r[5];
    if (m == 2'h2) h[5] = r[5] | f[5];
    aec_edge_mode <= m;
    pins <= nv;
    @(posedge core_clk);
    p1 |= pin_int_func[0] ? h[7:3] : 5'h00;
    wk |= pin_int_func[0] ? h[15:8] : 8'h00;
    @(posedge core_clk);
    `CHK("evt", h[2:0], evt)
  endtask
  task automatic boot();
    do @(posedge core_clk); while (!pc_load);
    `CHK("pc", 16'h0100, pc_value)
    `CHK("vaddr", 16'h0000, vec_rd_addr)
    foreach (ri[k]) rd(ri[k], rv[k]);
  endtask
  function automatic int best();
    int vt[14] = '{4, 5, 6, 7, 8, 9, 11, 12, 13, 14, 15, 16, 19, 20};
    logic [13:0] c;
    c = {p2[7:6], p2[4:0], p1[7], wk != 0, p1[4:0]};
    best = 0;
    for (int k = 13; k >= 0; k--) if (c[k]) best = vt[k];
  endfunction
  initial begin
    {core_clk, nrst, external_init_pin, pins} = 19'h0FFFF;
    {pin_int_func, aec_edge_mode, periph_evt, lat, awvalid} = '0;
    {awaddr, araddr, wdata, wvalid, arvalid} = '0;
    {cond_code_reg_i_wr, cond_code_reg_i_val} = 2'h0;
    {bready, rready, wstrb} = 6'h3F;
    void'($urandom(86));
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (10) @(posedge core_clk);
    external_init_pin <= 1'b1;
    boot();
    rd(16'hFF00, 8'h00);
    `CHK("resp", 2'h2, rd_r)
    wr(IDX_PIN_EDGE, 8'hFF);
    rd(IDX_PIN_EDGE, 8'hFB);
    es = 8'($urandom) & 8'h1B;
    ws = 8'($urandom);
    wr(IDX_PIN_EDGE, es);
    wr(IDX_WAKE_EDGE, ws);
    repeat (3) put_pins(16'($urandom));
    rd(IDX_PEND_ONE, 8'h20);
    pin_int_func <= '1;
    repeat (6) put_pins(16'($urandom));
    rd(IDX_PEND_ONE, 8'(p1) | 8'h20);
    rd(IDX_WAKE_PEND, 8'(wk));
    wr(IDX_EN_ONE, 8'hBF);
    wr(IDX_EN_TWO, 8'hDF);
    repeat (8) begin
      lat <= 2'($urandom);
      b = 8'($urandom);
      w = 8'($urandom);
      periph_evt <= {b, 6'h00};
      @(posedge core_clk);
      periph_evt <= '0;
      p1 = (p1 | {b[7], 7'h00}) & w;
      p2 = (p2 | {b[0], b[1], 1'b0, b[2], b[3], b[4], b[5], b[6]}) & w;
      wk &= w;
      wr(IDX_PEND_ONE, w);
      wr(IDX_PEND_TWO, w);
      wr(IDX_WAKE_PEND, w);
      rd(IDX_PEND_ONE, 8'(p1) | 8'h20);
      rd(IDX_PEND_TWO, 8'(p2));
      v = best();
      rd(IDX_STATUS, {2'b10, v != 0, 5'(v)});
      `CHK("best", 5'(v), rd_v[4:0])
      if (v != 0) begin
        cond_code_reg_i_wr <= 1'b1;
        @(posedge core_clk);
        cond_code_reg_i_wr <= 1'b0;
        do @(posedge core_clk); while (!irq_req);
        `CHK("vector", 5'(v), irq_vector)
        do @(posedge core_clk); while (irq_req);
        `CHK("mask", 1'b1, mask_flag)
      end
    end
    put_pins(16'hFFFF);
    external_init_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    `CHK("halt", 1'b1, cpu_halt)
    external_init_pin <= 1'b1;
    boot();
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    fails++;
    give_verdict();
  end
endmodule
